// *** src/spa_pkg.sv ***
package spa_pkg;

  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int unsigned IR_W        = 4;
  localparam int unsigned UNLOCK_W    = 16;
  localparam int unsigned CMD_W       = 15;
  localparam int unsigned DR_W        = 16;
  localparam int unsigned CLR_CLKS    = 2;
  localparam int unsigned CLR_CNT_W   = 2;
  localparam int unsigned PIN_W       = 5;

  // ****************************************************************
  // Instruction codes
  // ****************************************************************
  localparam logic [3:0] IR_RESET_HOLD = 4'hC;
  localparam logic [3:0] IR_UNLOCK     = 4'h4;
  localparam logic [3:0] IR_COMMAND    = 4'h5;
  localparam logic [3:0] IR_BYPASS     = 4'hF;
  localparam logic [3:0] IR_CAPTURE    = 4'h1;

  // Arbitrary signature value
  localparam logic [15:0] UNLOCK_SIG   = 16'h5A3C;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0,
    TAP_IDLE     = 4'h1,
    TAP_SEL_DR   = 4'h2,
    TAP_CAP_DR   = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR   = 4'h8,
    TAP_SEL_IR   = 4'h9,
    TAP_CAP_IR   = 4'hA,
    TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC,
    TAP_PAUSE_IR = 4'hD,
    TAP_EXIT2_IR = 4'hE,
    TAP_UPD_IR   = 4'hF
  } spa_tap_e;

  typedef struct packed {
    logic fuse;
    logic ext_rst_n;
    logic tck;
    logic tms;
    logic tdi;
  } spa_pins_s;

endpackage : spa_pkg

// *** src/spa_scan_access.sv ***
`timescale 1ns/1ps
`default_nettype none

module spa_scan_access (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       tck_i,
  input  wire logic                       tms_i,
  input  wire logic                       tdi_i,
  input  wire logic                       ext_reset_n_i,
  input  wire logic                       scan_port_enable_fuse_i,
  input  wire logic                       dis_wr_i,
  input  wire logic                       dis_wdata_i,
  input  wire logic [spa_pkg::CMD_W-1:0]  prog_result_i,
  output logic                            tdo_o,
  output logic                            tdo_oe_o,
  output logic                            port_avail_o,
  output logic                            scan_port_disable_bit_o,
  output logic                            core_reset_hold_o,
  output logic                            prog_mode_o,
  output logic [spa_pkg::CMD_W-1:0]       prog_cmd_o,
  output logic                            prog_cmd_stb_o,
  output logic                            prog_clk_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic spa_pkg::spa_tap_e tap_next(
    input spa_pkg::spa_tap_e s,
    input logic              m
  );
    case (s)
      spa_pkg::TAP_RESET:    tap_next = m ? spa_pkg::TAP_RESET
                                          : spa_pkg::TAP_IDLE;
      spa_pkg::TAP_IDLE:     tap_next = m ? spa_pkg::TAP_SEL_DR
                                          : spa_pkg::TAP_IDLE;
      spa_pkg::TAP_SEL_DR:   tap_next = m ? spa_pkg::TAP_SEL_IR
                                          : spa_pkg::TAP_CAP_DR;
      spa_pkg::TAP_CAP_DR,
      spa_pkg::TAP_SHIFT_DR: tap_next = m ? spa_pkg::TAP_EXIT1_DR
                                          : spa_pkg::TAP_SHIFT_DR;
      spa_pkg::TAP_EXIT1_DR: tap_next = m ? spa_pkg::TAP_UPD_DR
                                          : spa_pkg::TAP_PAUSE_DR;
      spa_pkg::TAP_PAUSE_DR: tap_next = m ? spa_pkg::TAP_EXIT2_DR
                                          : spa_pkg::TAP_PAUSE_DR;
      spa_pkg::TAP_EXIT2_DR: tap_next = m ? spa_pkg::TAP_UPD_DR
                                          : spa_pkg::TAP_SHIFT_DR;
      spa_pkg::TAP_UPD_DR,
      spa_pkg::TAP_UPD_IR:   tap_next = m ? spa_pkg::TAP_SEL_DR
                                          : spa_pkg::TAP_IDLE;
      spa_pkg::TAP_SEL_IR:   tap_next = m ? spa_pkg::TAP_RESET
                                          : spa_pkg::TAP_CAP_IR;
      spa_pkg::TAP_CAP_IR,
      spa_pkg::TAP_SHIFT_IR: tap_next = m ? spa_pkg::TAP_EXIT1_IR
                                          : spa_pkg::TAP_SHIFT_IR;
      spa_pkg::TAP_EXIT1_IR: tap_next = m ? spa_pkg::TAP_UPD_IR
                                          : spa_pkg::TAP_PAUSE_IR;
      spa_pkg::TAP_PAUSE_IR: tap_next = m ? spa_pkg::TAP_EXIT2_IR
                                          : spa_pkg::TAP_PAUSE_IR;
      spa_pkg::TAP_EXIT2_IR: tap_next = m ? spa_pkg::TAP_UPD_IR
                                          : spa_pkg::TAP_SHIFT_IR;
      default:               tap_next = spa_pkg::TAP_RESET;
    endcase
  endfunction : tap_next

  // Shift right by one inside a chain of length len, new bit on top
  function automatic logic [spa_pkg::DR_W-1:0] dr_shift(
    input logic [spa_pkg::DR_W-1:0] sr,
    input logic                     d,
    input int unsigned              len
  );
    for (int unsigned i = 0; i < spa_pkg::DR_W; i++) begin
      if (i + 1 == len) begin
        dr_shift[i] = d;
      end else if (i + 1 < len) begin
        dr_shift[i] = sr[i+1];
      end else begin
        dr_shift[i] = 1'b0;
      end
    end
  endfunction : dr_shift

  // ****************************************************************
  // Pin synchronisers and edge detect
  // ****************************************************************
  spa_pkg::spa_pins_s pins_raw;
  spa_pkg::spa_pins_s pins_s;
  logic               tck_q_ff;

  assign pins_raw = '{fuse:      scan_port_enable_fuse_i,
                      ext_rst_n: ext_reset_n_i,
                      tck:       tck_i,
                      tms:       tms_i,
                      tdi:       tdi_i};

  spa_sync #(
    .W (spa_pkg::PIN_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pins_raw),
    .q_o   (pins_s)
  );

  wire logic tck_rise = pins_s.tck & ~tck_q_ff;
  wire logic tck_fall = ~pins_s.tck & tck_q_ff;

  // ****************************************************************
  // Disable bit and availability
  // ****************************************************************
  logic                          dis_ff;
  logic [spa_pkg::CLR_CNT_W-1:0] clr_cnt_ff;

  wire logic ext_low   = dis_ff & ~pins_s.ext_rst_n;
  wire logic clr_done  = ext_low &
    (clr_cnt_ff == spa_pkg::CLR_CNT_W'(spa_pkg::CLR_CLKS - 1));
  wire logic avail     = pins_s.fuse & ~dis_ff;

  logic [spa_pkg::CLR_CNT_W-1:0] nxt_clr_cnt;
  logic                          nxt_dis;

  assign nxt_clr_cnt = ext_low ? clr_cnt_ff + 1'b1 : '0;
  assign nxt_dis     = dis_wr_i ? dis_wdata_i
                     : (clr_done ? 1'b0 : dis_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_ff       <= 1'b0;
      clr_cnt_ff   <= '0;
      tck_q_ff     <= 1'b0;
      port_avail_o <= 1'b0;
    end else begin
      dis_ff       <= nxt_dis;
      clr_cnt_ff   <= clr_done ? '0 : nxt_clr_cnt;
      tck_q_ff     <= pins_s.tck;
      port_avail_o <= avail;
    end
  end

  assign scan_port_disable_bit_o = dis_ff;

  // ****************************************************************
  // Test controller, instruction and data chains
  // ****************************************************************
  spa_pkg::spa_tap_e          state_ff;
  logic [spa_pkg::IR_W-1:0]   ir_sr_ff;
  logic [spa_pkg::IR_W-1:0]   ir_ff;
  logic [spa_pkg::DR_W-1:0]   dr_sr_ff;
  logic                       rst_chain_ff;

  wire logic sel_rst = ir_ff == spa_pkg::IR_RESET_HOLD;
  wire logic sel_unl = ir_ff == spa_pkg::IR_UNLOCK;
  wire logic sel_cmd = ir_ff == spa_pkg::IR_COMMAND;
  wire logic [4:0] dr_len  = sel_unl ? 5'(spa_pkg::UNLOCK_W)
                           : (sel_cmd ? 5'(spa_pkg::CMD_W) : 5'h01);
  wire logic st_sir  = state_ff == spa_pkg::TAP_SHIFT_IR;
  wire logic st_sdr  = state_ff == spa_pkg::TAP_SHIFT_DR;
  wire logic st_cdr  = state_ff == spa_pkg::TAP_CAP_DR;
  wire logic st_udr  = state_ff == spa_pkg::TAP_UPD_DR;
  wire logic st_idle = state_ff == spa_pkg::TAP_IDLE;
  wire logic tdo_nxt = st_sir ? ir_sr_ff[0]
                     : (sel_rst ? rst_chain_ff : dr_sr_ff[0]);
  wire logic unl_ok  = dr_sr_ff == spa_pkg::UNLOCK_SIG;

  always_ff @(posedge clk_i) begin
    if (rst_i || !avail) begin
      state_ff <= spa_pkg::TAP_RESET;
    end else if (tck_rise) begin
      state_ff <= tap_next(state_ff, pins_s.tms);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == spa_pkg::TAP_RESET) begin
      ir_sr_ff <= '0;
      ir_ff    <= spa_pkg::IR_BYPASS;
    end else if (tck_rise) begin
      case (state_ff)
        spa_pkg::TAP_CAP_IR:   ir_sr_ff <= spa_pkg::IR_CAPTURE;
        spa_pkg::TAP_SHIFT_IR: ir_sr_ff <=
          {pins_s.tdi, ir_sr_ff[spa_pkg::IR_W-1:1]};
        spa_pkg::TAP_UPD_IR:   ir_ff    <= ir_sr_ff;
        default:               ir_sr_ff <= ir_sr_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dr_sr_ff <= '0;
    end else if (tck_rise && st_cdr) begin
      dr_sr_ff <= sel_cmd ? spa_pkg::DR_W'(prog_result_i) : '0;
    end else if (tck_rise && st_sdr && !sel_rst) begin
      dr_sr_ff <= dr_shift(dr_sr_ff, pins_s.tdi, dr_len);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_chain_ff <= 1'b0;
    end else if (tck_rise && st_sdr && sel_rst) begin
      rst_chain_ff <= pins_s.tdi;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o             <= 1'b0;
      tdo_oe_o          <= 1'b0;
      core_reset_hold_o <= 1'b0;
      prog_mode_o       <= 1'b0;
      prog_cmd_o        <= '0;
      prog_cmd_stb_o    <= 1'b0;
      prog_clk_o        <= 1'b0;
    end else begin
      if (!avail) begin
        tdo_oe_o <= 1'b0;
      end else if (tck_fall) begin
        tdo_o    <= tdo_nxt;
        tdo_oe_o <= st_sir | st_sdr;
      end
      core_reset_hold_o <= rst_chain_ff;
      if (tck_rise && st_udr && sel_unl) begin
        prog_mode_o <= unl_ok;
      end
      if (tck_rise && st_udr && sel_cmd) begin
        prog_cmd_o <= dr_sr_ff[spa_pkg::CMD_W-1:0];
      end
      prog_cmd_stb_o <= tck_rise & st_udr & sel_cmd;
      prog_clk_o     <= tck_rise & st_idle;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ext_low2;
    (dis_ff && !pins_s.ext_rst_n && !dis_wr_i)[*2];
  endsequence
  AST_DIS_CLEAR: assert property (
    s_ext_low2 |=> !dis_ff)
    else $error("disable bit not cleared after two clocks");
  AST_PORT_GATED: assert property (
    !avail |=> state_ff == spa_pkg::TAP_RESET && !tdo_oe_o)
    else $error("test port active while unavailable");
  AST_IR_LSB: assert property (
    tck_rise && st_sir |=>
      ir_sr_ff == {$past(pins_s.tdi), $past(ir_sr_ff[3:1])})
    else $error("instruction shift not lsb first");
  AST_IR_UPDATE: assert property (
    tck_rise && state_ff == spa_pkg::TAP_UPD_IR && avail
      |=> ir_ff == $past(ir_sr_ff))
    else $error("instruction not updated");
  AST_RST_HOLD: assert property (
    tck_rise && st_sdr && sel_rst && avail
      |=> ##1 core_reset_hold_o == $past(pins_s.tdi, 2))
    else $error("reset hold does not follow chain");
  AST_UNLOCK: assert property (
    tck_rise && st_udr && sel_unl |=>
      prog_mode_o == ($past(dr_sr_ff) == spa_pkg::UNLOCK_SIG))
    else $error("unlock compare wrong");
  AST_CMD_APPLY: assert property (
    tck_rise && st_udr && sel_cmd |=>
      prog_cmd_stb_o && prog_cmd_o == $past(dr_sr_ff[14:0]))
    else $error("command not applied on update");
  AST_CMD_CAPTURE: assert property (
    tck_rise && st_cdr && sel_cmd |=>
      dr_sr_ff[14:0] == $past(prog_result_i))
    else $error("result not captured");
  AST_UNL_SHIFT: assert property (
    tck_rise && st_sdr && sel_unl |=>
      dr_sr_ff == {$past(pins_s.tdi), $past(dr_sr_ff[15:1])})
    else $error("unlock chain shift wrong");
  AST_PROG_CLK: assert property (
    prog_clk_o |-> $past(tck_rise) && $past(st_idle))
    else $error("programming clock outside idle");
endmodule : spa_scan_access

`default_nettype wire

// *** src/spa_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module spa_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule : spa_sync

`default_nettype wire

// *** test/spa_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Programmer model on the four test pins
// ****************************************************************
module spa_prog_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic oe_ok;
  logic oe_seen;

  initial begin
    tck_o   = 1'b0;
    tms_o   = 1'b0;
    tdi_o   = 1'b0;
    oe_ok   = 1'b1;
    oe_seen = 1'b0;
  end

  // One test clock period, 48 ns; clock stands low between calls
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #24;
    // Released output shows the inverse of its last value
    tdo     = tdo_oe_i ? tdo_i : ~tdo_i;
    oe_seen = tdo_oe_i;
    tck_o   = 1'b1;
    #24;
    tck_o = 1'b0;
  endtask : tick

  // Five mode-high clocks, then park in idle
  task automatic to_idle;
    logic d;
    repeat (5) tick(1'b1, ~tdi_o, d);
    tick(1'b0, ~tdi_o, d);
  endtask : to_idle

  // Quiet clocks in idle between sequences
  task automatic idle(input int n);
    logic d;
    repeat (n) tick(1'b0, ~tdi_o, d);
  endtask : idle

  // Scan from idle back to idle, low bit first, four pins only
  task automatic scan(input logic ir, input logic [15:0] din,
                      input int len, output logic [15:0] dout);
    logic d;
    dout  = '0;
    oe_ok = 1'b1;
    tick(1'b1, ~tdi_o, d);
    if (ir) begin
      tick(1'b1, ~tdi_o, d);
    end
    tick(1'b0, ~tdi_o, d);
    tick(1'b0, ~tdi_o, d);
    for (int i = 0; i < len; i++) begin
      tick(i == len - 1, din[i], d);
      oe_ok   = oe_ok & oe_seen;
      dout[i] = d;
    end
    tick(1'b1, ~tdi_o, d);
    tick(1'b0, ~tdi_o, d);
  endtask : scan

endmodule : spa_prog_model

`default_nettype wire

// *** test/spa_scan_access_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  errors++; $display("BAD %s exp %0h got %0h", nm, exp, got); end end

// ****************************************************************
// Bench top
// ****************************************************************
module spa_scan_access_bench;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        fuse     = 1'b1;
  logic        ext_n    = 1'b1;
  logic        dis_wr   = 1'b0;
  logic        dis_wd   = 1'b0;
  logic [14:0] result   = '0;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo_o;
  logic        tdo_oe_o;
  logic        port_avail_o;
  logic        dis_o;
  logic        hold_o;
  logic        mode_o;
  logic [14:0] cmd_o;
  logic        stb_o;
  logic        pclk_o;
  logic [15:0] dout;
  int          errors   = 0;
  int          n_checks = 0;
  int          n_stb    = 0;
  int          n_pclk   = 0;
  int          base;

  spa_scan_access i_spa_scan_access (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .ext_reset_n_i(ext_n), .scan_port_enable_fuse_i(fuse),
    .dis_wr_i(dis_wr), .dis_wdata_i(dis_wd), .prog_result_i(result),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .port_avail_o(port_avail_o),
    .scan_port_disable_bit_o(dis_o), .core_reset_hold_o(hold_o),
    .prog_mode_o(mode_o), .prog_cmd_o(cmd_o), .prog_cmd_stb_o(stb_o),
    .prog_clk_o(pclk_o));

  spa_prog_model i_spa_prog_model (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o),
    .tdo_oe_i(tdo_oe_o));

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (stb_o === 1'b1) n_stb++;
    if (pclk_o === 1'b1) n_pclk++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_avail;
    #1 `CHK("avail", 1'b1, port_avail_o)
    step(1);
    fuse <= 1'b0;
    step(8);
    #1 `CHK("avail nofuse", 1'b0, port_avail_o)
    step(1);
    fuse   <= 1'b1;
    dis_wr <= 1'b1;
    dis_wd <= 1'b1;
    step(1);
    dis_wr <= 1'b0;
    step(8);
    #1 `CHK("dis bit", 1'b1, dis_o)
    `CHK("avail dis", 1'b0, port_avail_o)
    i_spa_prog_model.scan(1'b1, 16'h000F, 4, dout);
    `CHK("tdo oe dis", 1'b0, i_spa_prog_model.oe_ok)
    $display("test avail done");
  endtask : t_avail

  task automatic t_clear;
    step(10);
    #1 `CHK("dis hold", 1'b1, dis_o)
    step(1);
    ext_n <= 1'b0;
    step(3);
    #1 `CHK("dis early", 1'b1, dis_o)
    step(4);
    #1 `CHK("dis clr", 1'b0, dis_o)
    step(1);
    ext_n <= 1'b1;
    step(6);
    #1 `CHK("avail back", 1'b1, port_avail_o)
    $display("test clear done");
  endtask : t_clear

  task automatic t_ir_bypass;
    i_spa_prog_model.to_idle();
    i_spa_prog_model.scan(1'b1, {12'h000, spa_pkg::IR_BYPASS}, 4, dout);
    `CHK("ir capture", 4'h1, dout[3:0])
    `CHK("tdo oe", 1'b1, i_spa_prog_model.oe_ok)
    i_spa_prog_model.scan(1'b0, 16'h00B5, 8, dout);
    `CHK("bypass", 8'h6A, dout[7:0])
    $display("test ir bypass done");
  endtask : t_ir_bypass

  task automatic t_hold;
    i_spa_prog_model.scan(1'b1, {12'h000, spa_pkg::IR_RESET_HOLD}, 4, dout);
    i_spa_prog_model.scan(1'b0, 16'h0001, 1, dout);
    step(8);
    #1 `CHK("hold set", 1'b1, hold_o)
    i_spa_prog_model.scan(1'b0, 16'h0000, 1, dout);
    step(8);
    #1 `CHK("hold clr", 1'b0, hold_o)
    $display("test hold done");
  endtask : t_hold

  task automatic t_unlock;
    i_spa_prog_model.scan(1'b1, {12'h000, spa_pkg::IR_UNLOCK}, 4, dout);
    i_spa_prog_model.scan(1'b0, spa_pkg::UNLOCK_SIG, 16, dout);
    step(8);
    #1 `CHK("mode on", 1'b1, mode_o)
    i_spa_prog_model.scan(1'b0, spa_pkg::UNLOCK_SIG ^ 16'h0001, 16, dout);
    step(8);
    #1 `CHK("mode off", 1'b0, mode_o)
    $display("test unlock done");
  endtask : t_unlock

  task automatic t_cmd;
    step(1);
    result <= 15'h1234;
    i_spa_prog_model.scan(1'b1, {12'h000, spa_pkg::IR_COMMAND}, 4, dout);
    base = n_stb;
    i_spa_prog_model.scan(1'b0, 16'h2A5B, 15, dout);
    step(8);
    #1 `CHK("cmd result", 15'h1234, dout[14:0])
    `CHK("cmd applied", 15'h2A5B, cmd_o)
    `CHK("cmd strobes", 1, n_stb - base)
    $display("test cmd done");
  endtask : t_cmd

  task automatic t_idle;
    step(8);
    base = n_pclk;
    i_spa_prog_model.idle(5);
    step(8);
    #1 `CHK("idle clocks", 5, n_pclk - base)
    $display("test idle done");
  endtask : t_idle

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    step(16);
    rst_i <= 1'b0;
    step(4);
    t_avail();
    t_clear();
    t_ir_bypass();
    t_hold();
    t_unlock();
    t_cmd();
    t_idle();
    wrap_up();
  end

  initial begin
    #100000;
    errors++;
    wrap_up();
  end

endmodule : spa_scan_access_bench

`default_nettype wire
